//--- dim_defs.svh
// Constants of the drive input map and indication output block.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef DIM_DEFS_SVH
`define DIM_DEFS_SVH
`define DIM_AW 4
`define DIM_DW 16
`define DIM_A_CTRL 4'h0
`define DIM_A_TRIM 4'h1
`define DIM_A_FACTOR 4'h2
`define DIM_A_ENDF 4'h3
`define DIM_A_IN1 4'h4
`define DIM_A_STATUS 4'h9
`define DIM_A_SCALED 4'hA
`define DIM_A_OUTF 4'hB
`define DIM_CTRL_RUNSRC 4
`define DIM_STAT_REJECT 15
`define DIM_SEL_POL 8
`define DIM_TRIM_RST 8'h50
`define DIM_FACTOR_RST 10'h00A
`define DIM_FACTOR_MAX 10'h3E7
`define DIM_ENDF_RST 12'h1F4
`define DIM_CUR_FULL 12'h0C8
`define DIM_FN_FWD 5'h00
`define DIM_FN_REV 5'h01
`define DIM_FN_FF1 5'h02
`define DIM_FN_FF2 5'h03
`define DIM_FN_FF3 5'h04
`define DIM_FN_FF4 5'h05
`define DIM_FN_JOG 5'h06
`define DIM_FN_2RAMP 5'h09
`define DIM_FN_COAST 5'h0B
`define DIM_FN_TRIP 5'h0C
`define DIM_FN_LOCKOUT 5'h0D
`define DIM_FN_PLOCK 5'h0F
`define DIM_FN_CURSP 5'h10
`define DIM_FN_FRESET 5'h12
`define DIM_FN_THERM 5'h13
`define DIM_CLK_HZ 40000000
`define DIM_ACC_W 40
// Round of 2^40 / (100 * clock rate): rate product is in 0.01 Hz
`define DIM_ACC_K 34'h113
`endif

//--- dim_pkg.sv
// Types of the drive input map and indication output block.
// Assumes dim_defs.svh is on the include path.
`default_nettype none
package dim_pkg;
    typedef enum logic [1:0] {
        DIM_IND_FREQ = 2'h0,
        DIM_IND_CURRENT = 2'h1,
        DIM_IND_PULSE = 2'h2
    } dim_ind_t;
    typedef struct packed {
        logic [3:0] fixed_speed;
        logic jog;
        logic second_ramp_select;
        logic coast_stop_input;
        logic external_trip_input;
        logic restart_lockout_input;
        logic parameter_lock_input;
        logic current_setpoint_select;
        logic fault_reset;
        logic thermistor_input;
    } dim_func_t;
    typedef struct packed {
        logic run_fwd;
        logic run_rev;
        logic ramp_stop;
    } dim_run_t;
endpackage : dim_pkg
`default_nettype wire

//--- dim_top.sv
// Digital input function map, run logic and indication output of a motor drive.
// Assumes clk at 40 MHz, contact inputs asynchronous, register port on clk.
`include "dim_defs.svh"
`default_nettype none
// How it works
// [R1] Source code 00 frequency width, 01 current width, 02 pulse train.
// [R2] Width modes keep a fixed period; high time grows linearly to end frequency.
// [R3] Full-load motor current gives half of full-scale width.
// [R4] Eight-bit trim, default 80, scales width modes only, writable any time.
// [R5] Pulse-train rate follows output frequency with half duty.
// [R6] Rate is frequency times factor 0.1 to 99.9; product readable as monitor.
// [R7] Each input has a function select; duplicate assignments are refused.
// [R8] Function codes decode to forward, reverse, fixed speed bits and the rest.
// [R9] Defaults: forward, reverse, 02, 03, 18 on inputs one to five.
// [R10] Polarity 00 active when closed, 01 active when open.
// [R11] Fault reset and thermistor inputs are always active when closed.
// [R12] Forward active starts clockwise; inactive ramps down.
// [R13] Reverse active starts anticlockwise; inactive ramps down.
// [R14] Forward and reverse both active ramps the motor down.
// [R15] Operator avoids break polarity on open run inputs; motor would start.
// [R16] Run source selects contact inputs (default) or keypad start key.
// [R17] Effective level is raw closed level exclusive-or polarity.
module dim_top #(
    parameter int PWM_STEPS = 256
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`DIM_AW-1:0] addr,
    input wire logic [`DIM_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`DIM_DW-1:0] rdata,
    input wire logic [4:0] contact_closed,
    input wire logic [11:0] output_freq,
    input wire logic [11:0] motor_current_pct,
    input wire logic key_run,
    input wire logic key_reverse,
    output logic indication_output,
    output dim_pkg::dim_func_t func_out,
    output dim_pkg::dim_run_t run_out
);
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [1:0] src_q;
    logic runsrc_q;
    logic [7:0] trim_q;
    logic [9:0] factor_q;
    logic [11:0] endf_q;
    logic [4:0] fsel_q [5];
    logic [4:0] pol_q;
    logic reject_q;
    logic [8:0] pwm_cnt_q;
    logic [8:0] duty_q;
    logic [`DIM_ACC_W-1:0] acc_q;

    // Decode of the register port
    wire [2:0] in_idx = 3'(addr - `DIM_A_IN1);
    wire sel_wr = wr && addr >= `DIM_A_IN1 && addr < `DIM_A_STATUS;
    wire [4:0] new_fn = wdata[4:0];
    logic dup;
    always_comb begin
        dup = 1'b0;
        for (int j = 0; j < 5; j++) begin
            if (3'(j) != in_idx && fsel_q[j] == new_fn) dup = 1'b1; // R7
        end
    end
    wire fn_legal = new_fn <= `DIM_FN_JOG || new_fn == `DIM_FN_2RAMP
        || (new_fn >= `DIM_FN_COAST && new_fn <= `DIM_FN_LOCKOUT)
        || new_fn == `DIM_FN_PLOCK || new_fn == `DIM_FN_CURSP
        || new_fn == `DIM_FN_FRESET || (new_fn == `DIM_FN_THERM && in_idx == 3'h4); // R8
    wire sel_ok = sel_wr && !dup && fn_legal; // R7
    wire fac_wr = wr && addr == `DIM_A_FACTOR;
    wire fac_ok = fac_wr && wdata[9:0] != 10'h000 && wdata[9:0] <= `DIM_FACTOR_MAX; // R6
    // Set wins over the clear so a refusal in the clearing cycle is kept
    wire reject_set = (sel_wr && !sel_ok) || (fac_wr && !fac_ok);
    wire reject_clr = wr && addr == `DIM_A_STATUS && wdata[`DIM_STAT_REJECT];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            src_q <= 2'h0;
            runsrc_q <= 1'b0;
            trim_q <= `DIM_TRIM_RST;
            factor_q <= `DIM_FACTOR_RST;
            endf_q <= `DIM_ENDF_RST;
            fsel_q[0] <= `DIM_FN_FWD; // R9
            fsel_q[1] <= `DIM_FN_REV; // R9
            fsel_q[2] <= `DIM_FN_FF1; // R9
            fsel_q[3] <= `DIM_FN_FF2; // R9
            fsel_q[4] <= `DIM_FN_FRESET; // R9
            pol_q <= 5'h00;
            reject_q <= 1'b0;
        end else begin
            if (wr && addr == `DIM_A_CTRL && wdata[1:0] != 2'h3) src_q <= wdata[1:0]; // R1
            if (wr && addr == `DIM_A_CTRL) runsrc_q <= wdata[`DIM_CTRL_RUNSRC]; // R16
            if (wr && addr == `DIM_A_TRIM) trim_q <= wdata[7:0]; // R4
            if (fac_ok) factor_q <= wdata[9:0]; // R6
            if (wr && addr == `DIM_A_ENDF && wdata[11:0] != 12'h000) endf_q <= wdata[11:0];
            if (sel_ok) begin
                fsel_q[in_idx] <= new_fn; // R7
                pol_q[in_idx] <= wdata[`DIM_SEL_POL]; // R10
            end
            if (reject_set) reject_q <= 1'b1;
            else if (reject_clr) reject_q <= 1'b0;
        end
    end

    // Contact inputs: two-stage synchroniser, then polarity
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= contact_closed;
            sync2_q <= sync1_q;
        end
    end
    logic [4:0] eff;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (fsel_q[i] == `DIM_FN_FRESET || fsel_q[i] == `DIM_FN_THERM) begin
                eff[i] = sync2_q[i]; // R11
            end else begin
                eff[i] = sync2_q[i] ^ pol_q[i]; // R17 R10
            end
        end
    end
    function automatic logic fn_on(input logic [4:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (fsel_q[i] == code && eff[i]) hit = 1'b1;
        end
        return hit;
    endfunction
    // In a process: a continuous assign would not see fsel_q or eff change
    logic fwd_on;
    logic rev_on;
    dim_pkg::dim_func_t func_d;
    dim_pkg::dim_run_t run_d;
    always_comb begin
        fwd_on = fn_on(`DIM_FN_FWD);
        rev_on = fn_on(`DIM_FN_REV);
        func_d.fixed_speed = {fn_on(`DIM_FN_FF4), fn_on(`DIM_FN_FF3),
            fn_on(`DIM_FN_FF2), fn_on(`DIM_FN_FF1)}; // R8
        func_d.jog = fn_on(`DIM_FN_JOG);
        func_d.second_ramp_select = fn_on(`DIM_FN_2RAMP);
        func_d.coast_stop_input = fn_on(`DIM_FN_COAST);
        func_d.external_trip_input = fn_on(`DIM_FN_TRIP);
        func_d.restart_lockout_input = fn_on(`DIM_FN_LOCKOUT);
        func_d.parameter_lock_input = fn_on(`DIM_FN_PLOCK);
        func_d.current_setpoint_select = fn_on(`DIM_FN_CURSP);
        func_d.fault_reset = fn_on(`DIM_FN_FRESET);
        func_d.thermistor_input = fn_on(`DIM_FN_THERM);
        if (runsrc_q) begin
            run_d.run_fwd = key_run && !key_reverse; // R16
            run_d.run_rev = key_run && key_reverse;
        end else begin
            run_d.run_fwd = fwd_on && !rev_on; // R12 R14
            run_d.run_rev = rev_on && !fwd_on; // R13 R14
        end
        run_d.ramp_stop = !(run_d.run_fwd || run_d.run_rev); // R12 R13 R14
    end

    // Width modes: value scaled to steps, then trimmed; clamp at full scale
    wire is_cur = src_q == dim_pkg::DIM_IND_CURRENT;
    wire [11:0] ind_val = is_cur ? motor_current_pct : output_freq;
    wire [11:0] ind_full = is_cur ? `DIM_CUR_FULL : endf_q; // R3
    wire [23:0] raw_w = 24'(ind_val) * 24'(PWM_STEPS) / 24'(ind_full); // R2
    wire [31:0] trimmed = 32'(raw_w) * 32'(trim_q) / 32'(`DIM_TRIM_RST); // R4
    wire [8:0] duty_d = trimmed > 32'(PWM_STEPS) ? 9'(PWM_STEPS) : trimmed[8:0];
    wire pwm_wrap = pwm_cnt_q == 9'(PWM_STEPS - 1);
    // Pulse train: phase accumulator, top bit gives half duty
    wire [21:0] rate_p = 22'(output_freq) * 22'(factor_q); // R6
    wire [`DIM_ACC_W-1:0] acc_inc = `DIM_ACC_W'(34'(rate_p) * `DIM_ACC_K); // R5
    wire [21:0] scaled_full = rate_p / 22'h00000A;
    wire [15:0] scaled_mon = scaled_full > 22'h00FFFF ? 16'hFFFF : scaled_full[15:0];
    wire ind_d = src_q == dim_pkg::DIM_IND_PULSE ? acc_q[`DIM_ACC_W-1] : // R1 R5
        pwm_cnt_q < duty_q; // R2

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwm_cnt_q <= 9'h000;
            duty_q <= 9'h000;
            acc_q <= '0;
            indication_output <= 1'b0;
            func_out <= '0;
            run_out <= 3'b001;
        end else begin
            pwm_cnt_q <= pwm_wrap ? 9'h000 : pwm_cnt_q + 9'h001; // R2
            if (pwm_wrap) duty_q <= duty_d; // R2
            acc_q <= acc_q + acc_inc; // R5
            indication_output <= ind_d;
            func_out <= func_d; // R8
            run_out <= run_d;
        end
    end

    // Read port, data one cycle after the strobe
    logic [`DIM_DW-1:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (addr == `DIM_A_CTRL) rd_mux = {11'h000, runsrc_q, 2'h0, src_q};
        else if (addr == `DIM_A_TRIM) rd_mux = {8'h00, trim_q};
        else if (addr == `DIM_A_FACTOR) rd_mux = {6'h00, factor_q};
        else if (addr == `DIM_A_ENDF) rd_mux = {4'h0, endf_q};
        else if (addr >= `DIM_A_IN1 && addr < `DIM_A_STATUS)
            rd_mux = {7'h00, pol_q[in_idx], 3'h0, fsel_q[in_idx]};
        else if (addr == `DIM_A_STATUS)
            rd_mux = {reject_q, 7'h00, run_out.ramp_stop, run_out.run_rev, run_out.run_fwd, eff};
        else if (addr == `DIM_A_SCALED) rd_mux = scaled_mon; // R6
        else if (addr == `DIM_A_OUTF) rd_mux = {4'h0, output_freq};
    end
    always_ff @(posedge clk) begin
        if (!rstn) rdata <= 16'h0000;
        else rdata <= rd ? rd_mux : 16'h0000;
    end

    property p_pulse_mode;
        @(posedge clk) disable iff (!rstn)
        src_q == dim_pkg::DIM_IND_PULSE |=> indication_output == $past(acc_q[`DIM_ACC_W-1]);
    endproperty
    a_pulse_mode: assert property (p_pulse_mode) else $error("pulse mode output wrong"); // R1
    property p_width;
        @(posedge clk) disable iff (!rstn)
        src_q != dim_pkg::DIM_IND_PULSE ##1 src_q != dim_pkg::DIM_IND_PULSE
        |-> indication_output == ($past(pwm_cnt_q) < $past(duty_q));
    endproperty
    a_width: assert property (p_width) else $error("width output wrong"); // R2
    property p_trim_wr;
        @(posedge clk) disable iff (!rstn)
        wr && addr == `DIM_A_TRIM |=> trim_q == $past(wdata[7:0]);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim not stored"); // R4
    property p_dup_refused;
        @(posedge clk) disable iff (!rstn)
        sel_wr && dup |=> fsel_q[$past(in_idx)] == $past(fsel_q[in_idx]) && reject_q;
    endproperty
    a_dup_refused: assert property (p_dup_refused) else $error("duplicate accepted"); // R7
    property p_reset_fn;
        @(posedge clk) disable iff (!rstn)
        fsel_q[4] == `DIM_FN_FRESET |-> eff[4] == sync2_q[4];
    endproperty
    a_reset_fn: assert property (p_reset_fn) else $error("fault reset inverted"); // R11
    property p_fwd_run;
        @(posedge clk) disable iff (!rstn)
        !runsrc_q && fwd_on && !rev_on |=> run_out.run_fwd && !run_out.ramp_stop;
    endproperty
    a_fwd_run: assert property (p_fwd_run) else $error("forward not run"); // R12
    property p_both_stop;
        @(posedge clk) disable iff (!rstn)
        !runsrc_q && fwd_on && rev_on |=> run_out.ramp_stop && !run_out.run_rev;
    endproperty
    a_both_stop: assert property (p_both_stop) else $error("both inputs not ramped"); // R14
    property p_pol;
        @(posedge clk) disable iff (!rstn)
        fsel_q[0] != `DIM_FN_FRESET && fsel_q[0] != `DIM_FN_THERM
        |-> eff[0] == (sync2_q[0] ^ pol_q[0]);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong"); // R17
    property p_key;
        @(posedge clk) disable iff (!rstn)
        runsrc_q && key_run |=> !run_out.ramp_stop;
    endproperty
    a_key: assert property (p_key) else $error("keypad run ignored"); // R16
    c_fwd: cover property (@(posedge clk) disable iff (!rstn) run_out.run_fwd);
    c_rev_then_stop: cover property (@(posedge clk) disable iff (!rstn)
        run_out.run_rev ##1 run_out.ramp_stop);
    c_reject: cover property (@(posedge clk) disable iff (!rstn) reject_set);
    property p_rev_run;
        @(posedge clk) disable iff (!rstn)
        !runsrc_q && rev_on && !fwd_on |=> run_out.run_rev && !run_out.ramp_stop;
    endproperty
    a_rev_run: assert property (p_rev_run) else $error("reverse not run"); // R13
    property p_fac_refused;
        @(posedge clk) disable iff (!rstn)
        fac_wr && !fac_ok |=> $stable(factor_q) && reject_q;
    endproperty
    a_fac_refused: assert property (p_fac_refused) else $error("bad factor accepted"); // R6
    property p_src_hold;
        @(posedge clk) disable iff (!rstn)
        wr && addr == `DIM_A_CTRL && wdata[1:0] == 2'h3 |=> $stable(src_q);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("reserved source taken"); // R1
    property p_illegal_fn;
        @(posedge clk) disable iff (!rstn)
        sel_wr && !fn_legal |=> reject_q;
    endproperty
    a_illegal_fn: assert property (p_illegal_fn) else $error("illegal code not flagged"); // R8
    property p_set_wins;
        @(posedge clk) disable iff (!rstn)
        reject_set |=> reject_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("refusal not flagged"); // R7
    property p_duty_load;
        @(posedge clk) disable iff (!rstn)
        pwm_wrap |=> duty_q == $past(duty_d);
    endproperty
    a_duty_load: assert property (p_duty_load) else $error("duty not reloaded at wrap"); // R2
    c_key_rev: cover property (@(posedge clk) disable iff (!rstn) runsrc_q && run_out.run_rev);
    c_pulse_high: cover property (@(posedge clk) disable iff (!rstn)
        src_q == dim_pkg::DIM_IND_PULSE && indication_output);
endmodule // dim_top
`default_nettype wire

//--- dim_far.sv
// Far side model: switch contacts on the five inputs, meter on the pin.
// Assumes the bench sets the wanted contact pattern and clears the meter.
`default_nettype none
module dim_far (
    input wire logic clk,
    input wire logic [4:0] want_closed,
    input wire logic meter_clr,
    input wire logic indication_output,
    output logic [4:0] contact_closed,
    output logic [15:0] hi_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contacts always drive a level; an open contact reads as 0, never floats
    assign contact_closed = want_closed;
    // Meter integrates high time, as a moving-coil meter averages the pin
    always_ff @(posedge clk) begin
        if (meter_clr) begin
            hi_cnt <= 16'h0000;
        end else begin
            hi_cnt <= hi_cnt + {15'h0000, indication_output};
        end
    end
endmodule // dim_far
`default_nettype wire

//--- dim_top_tb_top.sv
// Self-checking bench of dim_top: register port, contacts, run logic, pin.
// Assumes dim_far as contacts and meter; PWM_STEPS of 16 keeps runs short.
`include "dim_defs.svh"
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module dim_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [4:0] want = 5'h00;
    logic [4:0] contact_closed;
    logic [11:0] freq = 12'h000;
    logic [11:0] cur = 12'h000;
    logic key_run = 1'b0;
    logic key_rev = 1'b0;
    logic ind;
    logic clr = 1'b0;
    logic [15:0] hi_cnt;
    dim_pkg::dim_func_t func_out;
    dim_pkg::dim_run_t run_out;
    int num_errors = 0;
    int compares = 0;
    int k;
    logic [31:0] seed = 32'h0000001F;
    logic [4:0] c;
    logic [2:0] r;
    logic [4:0] codes [10] = '{5'h02, 5'h04, 5'h05, 5'h06, 5'h09,
        5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h10};
    int pos [10] = '{9, 11, 12, 8, 7, 6, 5, 4, 3, 2};
    dim_top #(.PWM_STEPS(16)) dut (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .contact_closed(contact_closed), .output_freq(freq),
        .motor_current_pct(cur), .key_run(key_run), .key_reverse(key_rev),
        .indication_output(ind), .func_out(func_out), .run_out(run_out));
    dim_far far (.clk(clk), .want_closed(want), .meter_clr(clr),
        .indication_output(ind), .contact_closed(contact_closed),
        .hi_cnt(hi_cnt));
    always #12.5 clk = ~clk;
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [2:0] exp_run(input logic [4:0] v);
        if (v[0] && !v[1]) return 3'h4;
        if (v[1] && !v[0]) return 3'h2;
        return 3'h1;
    endfunction
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
    endtask
    // Contacts pass two synchroniser stages plus a register; 5 edges is safe
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic meas(input int n);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        hold(n);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(`DIM_A_CTRL, 16'h0000);
        rd_chk(`DIM_A_TRIM, 16'h0050);
        rd_chk(`DIM_A_FACTOR, 16'h000A);
        rd_chk(`DIM_A_IN1, 16'h0000);
        rd_chk(`DIM_A_IN1 + 4'h1, 16'h0001);
        rd_chk(`DIM_A_IN1 + 4'h2, 16'h0002);
        rd_chk(`DIM_A_IN1 + 4'h3, 16'h0003);
        rd_chk(`DIM_A_IN1 + 4'h4, 16'h0012);
        rd_chk(`DIM_A_ENDF, 16'h01F4);
        `CHK(run_out, 3'h1)
        `CHK(func_out, 13'h0000)
        `CHK(ind, 1'b0)
        done("defaults");
        for (int i = 0; i < 24; i++) begin
            c = (i == 0) ? 5'h03 : 5'(xs());
            @(posedge clk);
            want <= c;
            hold(5);
            r = exp_run(c);
            `CHK(run_out, r)
            `CHK(func_out, {2'b00, c[3], c[2], 7'h00, c[4], 1'b0})
            rd_chk(`DIM_A_STATUS, {8'h00, r[0], r[1], r[2], c});
        end
        @(posedge clk);
        want <= 5'h00;
        done("contacts");
        wr_reg(`DIM_A_IN1 + 4'h2, 16'h0100);
        rd_chk(`DIM_A_IN1 + 4'h2, 16'h0002);
        rd_chk(`DIM_A_STATUS, 16'h8080);
        wr_reg(`DIM_A_STATUS, 16'h8000);
        wr_reg(`DIM_A_IN1 + 4'h2, 16'h0013);
        rd_chk(`DIM_A_IN1 + 4'h2, 16'h0002);
        wr_reg(`DIM_A_FACTOR, 16'h0000);
        wr_reg(`DIM_A_FACTOR, 16'h03E8);
        rd_chk(`DIM_A_FACTOR, 16'h000A);
        rd_chk(`DIM_A_STATUS, 16'h8080);
        wr_reg(`DIM_A_STATUS, 16'h8000);
        rd_chk(`DIM_A_STATUS, 16'h0080);
        wr_reg(`DIM_A_CTRL, 16'h0003);
        rd_chk(`DIM_A_CTRL, 16'h0000);
        done("refusal");
        for (int i = 0; i < 10; i++) begin
            wr_reg(`DIM_A_IN1 + 4'h2, {11'h000, codes[i]});
            want <= 5'h04;
            hold(5);
            `CHK(func_out, 13'h0001 << pos[i])
            @(posedge clk);
            want <= 5'h00;
        end
        // Break polarity only on non-run inputs, so no motor start
        wr_reg(`DIM_A_IN1 + 4'h2, 16'h0102);
        hold(5);
        `CHK(func_out[9], 1'b1)
        wr_reg(`DIM_A_IN1 + 4'h2, 16'h0002);
        wr_reg(`DIM_A_IN1 + 4'h4, 16'h0112);
        hold(5);
        `CHK(func_out[1], 1'b0)
        @(posedge clk);
        want <= 5'h10;
        hold(5);
        `CHK(func_out[1], 1'b1)
        wr_reg(`DIM_A_IN1 + 4'h4, 16'h0113);
        hold(5);
        `CHK(func_out[1:0], 2'b01)
        done("decode");
        wr_reg(`DIM_A_CTRL, 16'h0010);
        want <= 5'h01;
        hold(5);
        `CHK(run_out, 3'h1)
        @(posedge clk);
        key_run <= 1'b1;
        hold(3);
        `CHK(run_out, 3'h4)
        @(posedge clk);
        key_rev <= 1'b1;
        hold(3);
        `CHK(run_out, 3'h2)
        @(posedge clk);
        key_run <= 1'b0;
        want <= 5'h00;
        done("keypad");
        wr_reg(`DIM_A_CTRL, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            k = int'(xs() % 5);
            @(posedge clk);
            freq <= 12'(125 * k);
            hold(40);
            meas(64);
            `CHK(hi_cnt, 16'(16 * k))
        end
        @(posedge clk);
        freq <= 12'd250;
        wr_reg(`DIM_A_TRIM, 16'h00A0);
        hold(40);
        meas(64);
        `CHK(hi_cnt, 16'd64)
        wr_reg(`DIM_A_TRIM, 16'h0028);
        hold(40);
        meas(64);
        `CHK(hi_cnt, 16'd16)
        wr_reg(`DIM_A_TRIM, 16'h0050);
        wr_reg(`DIM_A_ENDF, 16'h0000);
        rd_chk(`DIM_A_ENDF, 16'h01F4);
        wr_reg(`DIM_A_ENDF, 16'h00FA);
        hold(40);
        meas(64);
        `CHK(hi_cnt, 16'd64)
        wr_reg(`DIM_A_CTRL, 16'h0001);
        cur <= 12'd100;
        hold(40);
        meas(64);
        `CHK(hi_cnt, 16'd32)
        done("width");
        wr_reg(`DIM_A_CTRL, 16'h0002);
        wr_reg(`DIM_A_FACTOR, 16'h03E7);
        wr_reg(`DIM_A_TRIM, 16'h0000);
        freq <= 12'hFFF;
        hold(40);
        // Rate near 977 clocks; window of two periods, half of it high
        meas(1954);
        `CHK(hi_cnt > 16'd900 && hi_cnt < 16'd1060, 1'b1)
        rd_chk(`DIM_A_SCALED, 16'hFFFF);
        @(posedge clk);
        freq <= 12'd300;
        wr_reg(`DIM_A_FACTOR, 16'h0019);
        rd_chk(`DIM_A_SCALED, 16'h02EE);
        rd_chk(`DIM_A_OUTF, 16'h012C);
        done("pulse");
        end_sim();
    end
endmodule // dim_top_tb_top
`default_nettype wire
